// ---- ccs_chk_assertions.sv ----
// clock register checks
`timescale 1ns/1ps
module ccs_chk (
    input logic sys_clk_i, reset_i, sfr_wr_i, sfr_rd_i, synth_enable_o, osc_enable_o,
    input logic usb_clk_from_synth_o, input logic [3:0] core_periods_o, spi_periods_o,
    input logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o);
wire w3 = sfr_wr_i && sfr_addr_i == 8'ha3;
default clocking @(posedge sys_clk_i); endclocking
default disable iff (reset_i);
property p_rate; spi_periods_o==4'h6 |-> core_periods_o==4'h6; endproperty
a_rate: assert property (p_rate) else $error("rate");
property p_resv; sfr_rd_i && sfr_addr_i==8'haf |=> sfr_rdata_o[7:1]==0; endproperty
a_resv: assert property (p_resv) else $error("resv");
property p_byp; w3 |=> ##1 osc_enable_o != $past(sfr_wdata_i[2], 2); endproperty
a_byp: assert property (p_byp) else $error("byp");
property p_usb; usb_clk_from_synth_o==osc_enable_o; endproperty
a_usb: assert property (p_usb) else $error("usb");
property p_en; w3 |=> ##1 synth_enable_o==$past(sfr_wdata_i[1], 2); endproperty
a_en: assert property (p_en) else $error("en");
property p_core; sfr_wr_i && sfr_addr_i==8'h8f |=> ##1
    core_periods_o==($past(sfr_wdata_i[0], 2) ? 4'h6 : 4'hc); endproperty
a_core: assert property (p_core) else $error("core");
property p_rst; $fell(reset_i) |-> sfr_rdata_o==0 && core_periods_o==4'hc; endproperty
a_rst: assert property (p_rst) else $error("rst");
property p_lock; sfr_rd_i && sfr_addr_i==8'ha3 |=> synth_enable_o || !sfr_rdata_o[0];
endproperty
a_lock: assert property (p_lock) else $error("lock");
endmodule // ccs_chk
bind ccs_clock_regs ccs_chk u_chk (.*);

// ---- ccs_clock_regs.v ----
// clock-control special function registers: core mode, spi rate, synthesizer
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_clock_regs (
    // clock and reset
    input  wire       sys_clk_i,
    input  wire       reset_i,
    // special function register access
    input  wire [7:0] sfr_addr_i,
    input  wire [7:0] sfr_wdata_i,
    input  wire       sfr_wr_i,
    input  wire       sfr_rd_i,
    output reg  [7:0] sfr_rdata_o,
    output wire       sfr_hit_o,
    // synthesizer analog interface
    input  wire       synth_lock_raw_i,
    output reg        synth_enable_o,
    output reg        external_clock_bypass_o,
    output reg        osc_enable_o,
    output reg        usb_clk_from_synth_o,
    output reg  [3:0] feedback_ratio_field_o,
    output reg  [3:0] input_ratio_field_o,
    // clock period selections
    output reg  [3:0] core_periods_o,
    output reg  [3:0] spi_periods_o
);

////////////////////////////////////////////////////////////////////////////////
reg  [7:0] core_clk_reg;
reg        spi_rate_reg;
reg        bypass_reg;
reg        enable_reg;
reg  [7:0] divider_reg;
reg        lock_meta_reg;
reg        lock_sync_reg;
wire       double_speed_core;
wire       synth_locked;
wire [7:0] synth_ctrl_read;
wire [7:0] spi_sel_read;

assign double_speed_core = core_clk_reg[`CCS_BIT_DOUBLE_SPEED];
assign synth_locked      = lock_sync_reg & enable_reg;
assign synth_ctrl_read   = {5'h00, bypass_reg, enable_reg, synth_locked};
assign spi_sel_read      = {7'h00, spi_rate_reg};
assign sfr_hit_o = (sfr_addr_i == `CCS_ADDR_CORE_CLK) | (sfr_addr_i == `CCS_ADDR_SYNTH_CTRL) |
                   (sfr_addr_i == `CCS_ADDR_SYNTH_DIV) | (sfr_addr_i == `CCS_ADDR_SPI_CLK_SEL);

////////////////////////////////////////////////////////////////////////////////
// lock status synchroniser
always @(posedge sys_clk_i) begin
    if (reset_i) begin
        lock_meta_reg <= 1'b0;
        lock_sync_reg <= 1'b0;
    end else begin
        lock_meta_reg <= synth_lock_raw_i;
        lock_sync_reg <= lock_meta_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register writes
always @(posedge sys_clk_i) begin
    if (reset_i) begin
        core_clk_reg <= `CCS_RESET_VALUE;
        spi_rate_reg <= 1'b0;
        bypass_reg   <= 1'b0;
        enable_reg   <= 1'b0;
        divider_reg  <= `CCS_RESET_VALUE;
    end else if (sfr_wr_i) begin
        case (sfr_addr_i)
            `CCS_ADDR_CORE_CLK:    core_clk_reg <= sfr_wdata_i;
            `CCS_ADDR_SPI_CLK_SEL: spi_rate_reg <= sfr_wdata_i[`CCS_BIT_SPI_RATE];
            `CCS_ADDR_SYNTH_CTRL: begin
                bypass_reg <= sfr_wdata_i[`CCS_BIT_BYPASS];
                enable_reg <= sfr_wdata_i[`CCS_BIT_ENABLE];
            end
            `CCS_ADDR_SYNTH_DIV:   divider_reg <= sfr_wdata_i;
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// read data, registered
always @(posedge sys_clk_i) begin
    if (reset_i) begin
        sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
        case (sfr_addr_i)
            `CCS_ADDR_CORE_CLK:    sfr_rdata_o <= core_clk_reg;
            `CCS_ADDR_SYNTH_CTRL:  sfr_rdata_o <= synth_ctrl_read;
            `CCS_ADDR_SYNTH_DIV:   sfr_rdata_o <= divider_reg;
            `CCS_ADDR_SPI_CLK_SEL: sfr_rdata_o <= spi_sel_read;
            default:               sfr_rdata_o <= 8'h00;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// clock steering outputs
always @(posedge sys_clk_i) begin
    if (reset_i) begin
        synth_enable_o          <= 1'b0;
        external_clock_bypass_o <= 1'b0;
        osc_enable_o            <= 1'b1;
        usb_clk_from_synth_o    <= 1'b1;
        feedback_ratio_field_o  <= 4'h0;
        input_ratio_field_o     <= 4'h0;
        core_periods_o          <= `CCS_PERIODS_SLOW;
        spi_periods_o           <= `CCS_PERIODS_SLOW;
    end else begin
        synth_enable_o          <= enable_reg;
        external_clock_bypass_o <= bypass_reg;
        osc_enable_o            <= ~bypass_reg;
        usb_clk_from_synth_o    <= ~bypass_reg;
        feedback_ratio_field_o  <= divider_reg[`CCS_FEEDBACK_HI:`CCS_FEEDBACK_LO];
        input_ratio_field_o     <= divider_reg[`CCS_INPUT_HI:`CCS_INPUT_LO];
        core_periods_o <= double_speed_core ? `CCS_PERIODS_FAST : `CCS_PERIODS_SLOW;
        if (!double_speed_core)
            spi_periods_o <= `CCS_PERIODS_SLOW;
        else
            spi_periods_o <= spi_rate_reg ? `CCS_PERIODS_SLOW : `CCS_PERIODS_FAST;
    end
end

endmodule // ccs_clock_regs

// ---- ccs_defines.vh ----
// constants for the clock-control register block
// What this block does
// - spi rate select acts only while double-speed core mode is set
// - in double-speed mode, select clear gives 6 periods, set gives 12
// - reserved bits of spi select and synth control read as zero
// - bypass set routes external clock past synthesizer, oscillator off
// - bypass clear selects synthesizer output as usb clock, oscillator on
// - synth enable bit turns synthesizer on when one, off when zero
// - hardware sets lock bit while locked, clears it when lock lost
// - divider holds feedback ratio in bits 7-4, input ratio in bits 3-0
// - all clock registers reset to zero
// - double-speed clear gives 12 periods per cycle, set gives 6
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
`define CCS_ADDR_CORE_CLK      8'h8f
`define CCS_ADDR_SYNTH_CTRL    8'ha3
`define CCS_ADDR_SYNTH_DIV     8'ha4
`define CCS_ADDR_SPI_CLK_SEL   8'haf
`define CCS_RESET_VALUE        8'h00
`define CCS_BIT_DOUBLE_SPEED   0
`define CCS_BIT_SPI_RATE       0
`define CCS_BIT_LOCKED         0
`define CCS_BIT_ENABLE         1
`define CCS_BIT_BYPASS         2
`define CCS_FEEDBACK_HI        7
`define CCS_FEEDBACK_LO        4
`define CCS_INPUT_HI           3
`define CCS_INPUT_LO           0
`define CCS_PERIODS_FAST       4'h6
`define CCS_PERIODS_SLOW       4'hc
`endif

// ---- testbench.sv ----
// register bench
`timescale 1ns/1ps
module testbench;
logic sys_clk_i=0, reset_i=1, sfr_wr_i=0, sfr_rd_i=0, synth_lock_raw_i=0;
logic [7:0] sfr_addr_i=0, sfr_wdata_i=0, sfr_rdata_o;
logic sfr_hit_o, synth_enable_o, external_clock_bypass_o, osc_enable_o, usb_clk_from_synth_o;
logic [3:0] feedback_ratio_field_o, input_ratio_field_o, core_periods_o, spi_periods_o;
int mismatches=0, checks=0;
logic [7:0] A[4]='{8'h8f, 8'ha3, 8'ha4, 8'haf};
ccs_clock_regs dut (.*);
initial forever #20 sys_clk_i=~sys_clk_i;
task complete_run;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches==0 && checks>0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
task chk(input logic [7:0] g, e);
    checks++;
    if (g!==e) begin
        mismatches++;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
endtask
task acc(input int r, input logic [7:0] a, d);
    @(posedge sys_clk_i) #1;
    {sfr_rd_i, sfr_wr_i, sfr_addr_i, sfr_wdata_i}={r==1, r==0, a, d};
    @(posedge sys_clk_i) #1;
    {sfr_rd_i, sfr_wr_i}=2'b00;
    if (r==1) begin
        checks++;
        if (sfr_rdata_o!==d) begin
            mismatches++;
            $display("CHECK FAILED %0t %h", $time, sfr_rdata_o);
        end
    end
endtask
initial begin
    repeat (4) @(posedge sys_clk_i);
    #1 reset_i=0;
    foreach (A[k]) acc(1, A[k], 8'h00);
    chk(sfr_hit_o, 8'h01);
    chk(osc_enable_o, 8'h01);
    chk(usb_clk_from_synth_o, 8'h01);
    chk(core_periods_o, 8'h0c);
    acc(1, 8'ha3, 8'h00);
    acc(0, 8'ha3, 8'h06);
    synth_lock_raw_i=1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(synth_enable_o, 8'h01);
    chk(external_clock_bypass_o, 8'h01);
    chk(osc_enable_o, 8'h00);
    chk(usb_clk_from_synth_o, 8'h00);
    acc(1, 8'ha3, 8'h07);
    acc(0, 8'ha4, 8'hb9);
    acc(1, 8'ha4, 8'hb9);
    chk(feedback_ratio_field_o, 8'h0b);
    chk(input_ratio_field_o, 8'h09);
    for (int i=0; i<4; i++) begin
        acc(0, 8'haf, 8'(i/2));
        acc(0, 8'h8f, 8'(i%2));
        @(posedge sys_clk_i) #1;
        chk(core_periods_o, (i%2) ? 8'h06 : 8'h0c);
        chk(spi_periods_o, (i==1) ? 8'h06 : 8'h0c);
    end
    acc(1, 8'haf, 8'h01);
    sfr_addr_i=8'ha5;
    #1 chk(sfr_hit_o, 8'h00);
    acc(1, 8'ha5, 8'h00);
    complete_run;
end
endmodule // testbench
